// ==== src/div_pkg.sv ====
// constants and helpers for the iterative divide unit
// Notes on behaviour
// - a divide completes over exactly 18 iterations, issued under repeat count 17.
// - a divide takes 18 iteration cycles plus one repeat setup cycle before.
// - on completion the 16-bit quotient and 16-bit remainder are written back.
// - fractional divide clears low dividend word and copies dividend into remainder.
package div_pkg;
  localparam int ITER_TOTAL = 18;
  localparam int SETUP_CYCLES = 1;
  localparam logic [4:0] RPT_COUNT = 5'(ITER_TOTAL - 1);
  localparam logic [4:0] CNT_STEP_FIRST = 5'h10;
  localparam logic [4:0] CNT_DONE = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] SIGNED_MAX = 16'h7FFF;
  localparam logic [15:0] SIGNED_MIN = 16'h8000;

  typedef enum logic [2:0] {
    signed_word_divide = 3'b000,
    unsigned_word_divide = 3'b001,
    signed_double_divide = 3'b010,
    unsigned_double_divide = 3'b011,
    fractional_divide = 3'b100
  } div_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } div_state_t;

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = 16'(~v + 16'h0001);
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] v, input logic sgn);
    abs16 = (sgn && v[15]) ? neg16(v) : v;
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v, input logic sgn);
    abs32 = (sgn && v[31]) ? 32'(~v + 32'h0000_0001) : v;
  endfunction
endpackage

// ==== src/div_step.sv ====
// one restoring divide step on unsigned magnitudes
`timescale 1ns/1ps
module div_step
  import div_pkg::*;
(
  div_step_if.step s
);
  wire [16:0] partial = s.no_shift ? {1'b0, s.rem} : {s.rem, s.quo[15]};
  wire [16:0] diff = 17'(partial - {1'b0, s.dvs});
  wire fits = (partial >= {1'b0, s.dvs});
  wire [16:0] kept = fits ? diff : partial;

  assign s.nxt_rem = kept[15:0];
  assign s.nxt_quo = {s.quo[14:0], fits};
endmodule

// ==== src/div_step_if.sv ====
// carrier between the divide controller and its restoring step
`timescale 1ns/1ps
interface div_step_if;
  logic [15:0] rem;
  logic [15:0] quo;
  logic [15:0] dvs;
  logic no_shift;
  logic [15:0] nxt_rem;
  logic [15:0] nxt_quo;
  modport ctrl (output rem, output quo, output dvs, output no_shift,
                input nxt_rem, input nxt_quo);
  modport step (input rem, input quo, input dvs, input no_shift,
                output nxt_rem, output nxt_quo);
endinterface

// ==== src/iterative_divide_unit.sv ====
// iterative signed, unsigned and fractional divide datapath
`timescale 1ns/1ps
module iterative_divide_unit
  import div_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sequencer control
  input wire logic repeat_setup,
  input wire logic iter_strobe,
  input wire logic [2:0] op_mode,
  // operand registers
  input wire logic [15:0] dividend_register,
  input wire logic [15:0] dividend_upper,
  input wire logic [15:0] divisor_register,
  // write back
  output logic wb_valid,
  output logic [15:0] quotient_register,
  output logic [15:0] remainder_register,
  // status
  output logic n_flag,
  output logic overflow_flag,
  output logic z_flag,
  output logic c_flag,
  output logic arith_trap,
  output logic busy
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  div_state_t state_ff, nxt_state;
  logic [4:0] cnt_ff;
  logic [15:0] rem_ff, quo_ff, dvs_ff;
  logic mode_sgn_ff, mode_frac_ff, ovpre_ff, qneg_ff, rneg_ff;
  logic wb_ff, trap_ff, n_ff, ov_ff, z_ff;
  logic [15:0] qout_ff, rout_ff;
  logic busy_ff, c_ff;

  ////////////////////////////////////////////////////////////////////////////
  // operand decode at the first iteration
  div_mode_t mode;
  assign mode = div_mode_t'(op_mode);
  wire is_signed = (mode == signed_word_divide) || (mode == signed_double_divide)
                   || (mode == fractional_divide);
  wire is_double = (mode == signed_double_divide) || (mode == unsigned_double_divide);
  wire is_frac = (mode == fractional_divide);
  wire [15:0] word_ext = (is_signed && dividend_register[15]) ? WORD_ONES : WORD_ZERO;
  wire [31:0] dividend_raw = is_double ? {dividend_upper, dividend_register}
                           : is_frac ? {dividend_register, WORD_ZERO}
                           : {word_ext, dividend_register};
  wire [31:0] dividend_mag = abs32(dividend_raw, is_signed);
  wire [15:0] divisor_mag = abs16(divisor_register, is_signed);
  wire dividend_neg = is_signed && dividend_raw[31];
  wire divisor_neg = is_signed && divisor_register[15];
  wire divisor_zero = (divisor_register == WORD_ZERO);
  wire pre_ov = (dividend_mag[31:16] >= divisor_mag);

  ////////////////////////////////////////////////////////////////////////////
  // iteration phases
  wire first_iter = (state_ff == ST_ARMED) && iter_strobe;
  wire step_iter = (state_ff == ST_RUN) && iter_strobe && (cnt_ff != CNT_DONE);
  wire last_iter = (state_ff == ST_RUN) && iter_strobe && (cnt_ff == CNT_DONE);

  div_step_if sif ();
  assign sif.rem = rem_ff;
  assign sif.quo = quo_ff;
  assign sif.dvs = dvs_ff;
  assign sif.no_shift = mode_frac_ff && (cnt_ff == CNT_STEP_FIRST);
  div_step u_step (.s(sif.step));

  ////////////////////////////////////////////////////////////////////////////
  // result correction on the last iteration
  wire [15:0] q_signed = qneg_ff ? neg16(quo_ff) : quo_ff;
  wire [15:0] r_signed = rneg_ff ? neg16(rem_ff) : rem_ff;
  wire q_too_big = mode_sgn_ff && (quo_ff > SIGNED_MAX)
                   && !(qneg_ff && (quo_ff == SIGNED_MIN));
  wire ov_final = ovpre_ff || q_too_big;
  wire r_negative = r_signed[15] && rneg_ff;
  wire r_zero = (r_signed == WORD_ZERO);
  wire trap_now = first_iter && divisor_zero;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (repeat_setup) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (iter_strobe) begin
          nxt_state = divisor_zero ? ST_IDLE : ST_RUN;
        end
      end
      ST_RUN: begin
        if (last_iter) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next count and state flag
  wire load_cnt = repeat_setup && (state_ff == ST_IDLE);
  wire dec_cnt = first_iter || step_iter;
  wire [4:0] cnt_less = 5'(cnt_ff - CNT_ONE);
  wire [4:0] nxt_cnt = load_cnt ? RPT_COUNT
                     : dec_cnt ? cnt_less
                     : cnt_ff;
  wire nxt_busy = (nxt_state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // next working pair and operand attributes
  wire [15:0] nxt_rem = first_iter ? dividend_mag[31:16]
                      : step_iter ? sif.nxt_rem
                      : rem_ff;
  wire [15:0] nxt_quo = first_iter ? dividend_mag[15:0]
                      : step_iter ? sif.nxt_quo
                      : quo_ff;
  wire [15:0] nxt_dvs = first_iter ? divisor_mag : dvs_ff;
  wire nxt_mode_sgn = first_iter ? is_signed : mode_sgn_ff;
  wire nxt_mode_frac = first_iter ? is_frac : mode_frac_ff;
  wire nxt_ovpre = first_iter ? pre_ov : ovpre_ff;
  wire nxt_qneg = first_iter ? (dividend_neg ^ divisor_neg) : qneg_ff;
  wire nxt_rneg = first_iter ? dividend_neg : rneg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // next results and flags
  wire [15:0] nxt_qout = last_iter ? q_signed : qout_ff;
  wire [15:0] nxt_rout = last_iter ? r_signed : rout_ff;
  wire nxt_n = last_iter ? r_negative : n_ff;
  wire nxt_ov = last_iter ? ov_final : ov_ff;
  wire nxt_z = last_iter ? r_zero : z_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_DONE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working pair
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rem_ff <= WORD_ZERO;
      quo_ff <= WORD_ZERO;
      dvs_ff <= WORD_ZERO;
    end else begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      dvs_ff <= nxt_dvs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand attributes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_sgn_ff <= 1'b0;
      mode_frac_ff <= 1'b0;
      ovpre_ff <= 1'b0;
      qneg_ff <= 1'b0;
      rneg_ff <= 1'b0;
    end else begin
      mode_sgn_ff <= nxt_mode_sgn;
      mode_frac_ff <= nxt_mode_frac;
      ovpre_ff <= nxt_ovpre;
      qneg_ff <= nxt_qneg;
      rneg_ff <= nxt_rneg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write back pulses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ff <= 1'b0;
      trap_ff <= 1'b0;
      c_ff <= 1'b0;
    end else begin
      wb_ff <= last_iter;
      trap_ff <= trap_now;
      c_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results and flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      qout_ff <= WORD_ZERO;
      rout_ff <= WORD_ZERO;
      n_ff <= 1'b0;
      ov_ff <= 1'b0;
      z_ff <= 1'b0;
    end else begin
      qout_ff <= nxt_qout;
      rout_ff <= nxt_rout;
      n_ff <= nxt_n;
      ov_ff <= nxt_ov;
      z_ff <= nxt_z;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_valid = wb_ff;
  assign quotient_register = qout_ff;
  assign remainder_register = rout_ff;
  assign n_flag = n_ff;
  assign overflow_flag = ov_ff;
  assign z_flag = z_ff;
  assign c_flag = c_ff;
  assign arith_trap = trap_ff;
  assign busy = busy_ff;
endmodule

// ==== tb/div_properties.sv ====
// port checker for the iterative divide unit
`timescale 1ns/1ps
module div_properties
  import div_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sequencer control
  input wire logic repeat_setup,
  input wire logic iter_strobe,
  input wire logic [15:0] divisor_register,
  // results
  input wire logic wb_valid,
  input wire logic [15:0] quotient_register,
  input wire logic arith_trap,
  input wire logic busy
);
  logic [4:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (!nrst || (repeat_setup && !busy)) cnt_ff <= 5'h00;
    else if (iter_strobe && busy) cnt_ff <= cnt_ff + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence first_step;
    busy && iter_strobe && cnt_ff == 5'h00;
  endsequence
  sequence zero_first;
    first_step ##0 (divisor_register == 16'h0000);
  endsequence
  //////////////////////////////////////////////////////////////////
  chk_busy_after_setup: assert property (repeat_setup && !busy |=> busy)
    else $error("busy not raised after setup");
  chk_eighteen_iters: assert property (wb_valid |-> cnt_ff == 5'h12 && !busy)
    else $error("write back not after 18 iterations");
  chk_stall_holds: assert property (busy && !iter_strobe |=> busy)
    else $error("divide ended without a strobe");
  chk_idle_ignores: assert property (!busy && iter_strobe && !repeat_setup |=> !busy)
    else $error("idle strobe started a divide");
  chk_wb_pulse: assert property (wb_valid |=> !wb_valid)
    else $error("write back longer than one cycle");
  chk_result_holds: assert property (nrst && $past(nrst) && !wb_valid |-> $stable(quotient_register))
    else $error("quotient changed without write back");
  chk_zero_traps: assert property (zero_first |=> arith_trap && !busy)
    else $error("zero divisor did not trap");
  chk_trap_cause: assert property (first_step ##0 divisor_register != 16'h0000 |=> !arith_trap)
    else $error("trap with nonzero divisor");
  chk_trap_no_wb: assert property (arith_trap |-> !wb_valid && !busy)
    else $error("write back on trap");
endmodule
bind iterative_divide_unit div_properties chk (.clk, .nrst, .repeat_setup, .iter_strobe,
  .divisor_register, .wb_valid, .quotient_register, .arith_trap, .busy);

// ==== tb/seq_model.sv ====
// sequencer model issuing repeat setup and iteration strobes
`timescale 1ns/1ps
module seq_model (
  // control
  input wire logic clk,
  input wire logic go,
  input wire logic stall,
  // to the unit
  output logic repeat_setup,
  output logic iter_strobe,
  output logic done
);
  int n = -1;
  logic setup_ff = 1'b0;
  logic strobe_ff = 1'b0;
  logic done_ff = 1'b0;
  assign repeat_setup = setup_ff;
  assign iter_strobe = strobe_ff;
  assign done = done_ff;
  always @(posedge clk) begin
    setup_ff <= go && n < 0;
    done_ff <= n == 18;
    if (go && n < 0) n <= 0;
    else if (n == 18 || n < 0) begin
      strobe_ff <= 1'b0;
      n <= -1;
    end else begin
      strobe_ff <= !(stall && strobe_ff);
      if (!(stall && strobe_ff)) n <= n + 1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the divide unit
`timescale 1ns/1ps
module testbench;
  import div_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic [2:0] op_mode = 3'h0;
  logic [15:0] dvd = 16'h0000, upr = 16'h0000, dvs = 16'h0001, lfsr = 16'h003E, ra, rb;
  logic rs, st, done, wb_valid, n_flag, ov, z_flag, c_flag, trap, busy;
  logic [15:0] quo, rem;
  logic [33:0] exp_q[$];
  logic [33:0] e, m;
  logic [2:0] f;
  int n_mismatch = 0;
  int comparisons = 0;
  int i;
  always #5 clk = ~clk;
  seq_model sq (.clk, .go, .stall, .repeat_setup(rs), .iter_strobe(st), .done);
  iterative_divide_unit uut (.clk, .nrst, .repeat_setup(rs), .iter_strobe(st), .op_mode,
    .dividend_register(dvd), .dividend_upper(upr), .divisor_register(dvs), .wb_valid,
    .quotient_register(quo), .remainder_register(rem), .n_flag, .overflow_flag(ov),
    .z_flag, .c_flag, .arith_trap(trap), .busy);
  //////////////////////////////////////////////////////////////////
  function automatic logic [15:0] step(input logic [15:0] x);
    step = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cmp(input logic [33:0] got, input logic [33:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic cmp_flags(input logic [2:0] got, input logic [2:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t flags got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic run(input logic [2:0] md, input logic [31:0] a, input logic [15:0] b,
                     input logic [33:0] x);
    int k;
    op_mode <= md;
    {upr, dvd} <= a;
    dvs <= b;
    exp_q.push_back(x);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 100 && done !== 1'b1; k++) @(negedge clk);
    if (done !== 1'b1) n_mismatch++;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (wb_valid === 1'b1 || trap === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("MISMATCH t=%0t extra got=%h exp=%h", $time, {trap, ov, quo, rem}, 34'h0);
      end else begin
        e = exp_q.pop_front();
        m = e[33] ? 34'h2_0000_0000 : e[32] ? 34'h1_0000_0000 : 34'h3_FFFF_FFFF;
        cmp({trap, ov, quo, rem} & m, e & m);
        if (e[33:32] == 2'b00) begin
          f = {e[15] && (op_mode != 3'h1) && (op_mode != 3'h3), e[15:0] == 16'h0000, 1'b0};
          cmp_flags({n_flag, z_flag, c_flag}, f);
        end
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run(3'h0, 32'h0000_3000, 16'h0027, 34'h0_013B_0003);
    run(3'h2, 32'hFF42_2500, 16'h2200, 34'h0_FA6B_EF00);
    run(3'h1, 32'h1234_8000, 16'h0200, 34'h0_0040_0000);
    run(3'h3, 32'h0042_2500, 16'h2200, 34'h0_01F2_0100);
    run(3'h4, 32'hFFFF_1000, 16'h4000, 34'h0_2000_0000);
    run(3'h4, 32'h0000_1000, 16'h8000, 34'h0_F000_0000);
    run(3'h4, 32'h0000_8002, 16'h8001, 34'h0_7FFE_8002);
    run(3'h3, 32'hFFFF_0000, 16'h0001, 34'h1_0000_0000);
    run(3'h0, 32'h0000_1234, 16'h0000, 34'h2_0000_0000);
    for (i = 0; i < 12; i++) begin
      lfsr = step(step(lfsr));
      ra = lfsr;
      rb = {8'h00, lfsr[7:0]} | 16'h0001;
      stall <= lfsr[0];
      run(3'h1, {16'h0000, ra}, rb, {2'b00, ra / rb, ra % rb});
    end
    if (exp_q.size() != 0) n_mismatch++;
    end_sim();
  end
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule
